// ### slpa_pkg.sv
// Shared constants and types for the strap latch and port address block.
// Assumes a single 200 MHz clock and an APB register slave with 32-bit data.
package slpa_pkg;

  // ***********************************************************************
  // Strap vector layout
  // ***********************************************************************
  localparam int ADDR_W = 5;
  localparam int MODE_W = 5;
  localparam int LAMP_N = 8;
  localparam int PORT_N = 4;
  localparam int STRAP_W = 20;
  localparam int SB_BASE = 0;
  localparam int SB_MODE = 5;
  localparam int SB_BCAST = 10;
  localparam int SB_STYLE = 11;
  localparam int SB_LAMP = 12;

  // Largest base address a board may strap
  localparam logic [ADDR_W-1:0] BASE_MAX = 5'h1c;
  localparam logic [ADDR_W-1:0] BCAST_ADDR = 5'h00;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_NS = 25;
  localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  // ***********************************************************************
  // APB register map
  // ***********************************************************************
  localparam int PADDR_W = 12;
  localparam logic [PADDR_W-1:0] REG_STRAPS = 12'h000;
  localparam logic [PADDR_W-1:0] REG_LAMP_POL = 12'h004;
  localparam logic [PADDR_W-1:0] REG_CONFIG = 12'h008;
  localparam logic [PADDR_W-1:0] REG_PORT_ADDR = 12'h00c;
  localparam logic [PADDR_W-1:0] REG_STATUS = 12'h010;
  localparam int RD_BASE = 0;
  localparam int RD_MODE = 8;
  localparam int RD_BCAST = 16;
  localparam int RD_STYLE = 17;
  localparam int RD_LAMP = 24;
  localparam int RD_PORT_STRIDE = 8;
  localparam int CFG_BCAST = 0;
  localparam int CFG_STYLE = 1;
  localparam int STAT_LATCHED = 0;
  localparam int STAT_OVER = 1;

  // Capture sequencer states
  typedef enum logic {CAP_SETTLE, CAP_HELD} slpa_cap_t;

endpackage

// ### slpa_sync3.sv
// Three-stage synchroniser with agreement filter for the strap pins.
// Assumes inputs are asynchronous to clk; output only follows agreed levels.
`timescale 1ns/1ps
module slpa_sync3 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [slpa_pkg::STRAP_W-1:0] pinIn,
  output logic [slpa_pkg::STRAP_W-1:0] agreed
);
  import slpa_pkg::*;

  typedef struct packed {
    logic [STRAP_W-1:0] s1;
    logic [STRAP_W-1:0] s2;
    logic [STRAP_W-1:0] s3;
    logic [STRAP_W-1:0] filt;
  } slpa_sync_st_t;

  slpa_sync_st_t st;
  slpa_sync_st_t next_st;

  // Stage one feeds only stage two; the filter looks at stages two and three
  always_comb begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
  end

  // Sync reset loads constants only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign agreed = st.filt;
endmodule

// ### slpa_port_map.sv
// Derives the four port management addresses and decodes an access address.
// Assumes base is stable once latched is high; broadcast enable can still change by a software write.
`timescale 1ns/1ps
module slpa_port_map (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic latched,
  input wire logic [slpa_pkg::ADDR_W-1:0] base,
  input wire logic bcastEn,
  input wire logic [slpa_pkg::ADDR_W-1:0] mgmtAddr,
  input wire logic mgmtAddrValid,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr0,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr1,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr2,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr3,
  output logic [slpa_pkg::PORT_N-1:0] portHit
);
  import slpa_pkg::*;

  typedef struct packed {
    logic [PORT_N-1:0][ADDR_W-1:0] addr;
    logic [PORT_N-1:0] hit;
  } slpa_map_st_t;

  slpa_map_st_t st;
  slpa_map_st_t next_st;
  logic [PORT_N-1:0][ADDR_W-1:0] calcAddr;
  logic [PORT_N-1:0] calcHit;

  // One address per port, base plus port index, in order
  for (genvar gi = 0; gi < PORT_N; gi++) begin : g_port
    assign calcAddr[gi] = ADDR_W'(base + ADDR_W'(gi));
    // Broadcast at address zero reaches every port when enabled
    assign calcHit[gi] = latched && mgmtAddrValid &&
      ((mgmtAddr == calcAddr[gi]) || (bcastEn && mgmtAddr == BCAST_ADDR));
  end

  always_comb begin
    next_st = st;
    next_st.addr = calcAddr;
    next_st.hit = calcHit;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign portAddr0 = st.addr[0];
  assign portAddr1 = st.addr[1];
  assign portAddr2 = st.addr[2];
  assign portAddr3 = st.addr[3];
  assign portHit = st.hit;
endmodule

// ### slpa_strap_latch.sv
// Strap capture, lamp polarity control and APB register slave.
// Assumes strap pins are held steady by board resistors around reset release.
`timescale 1ns/1ps
module slpa_strap_latch (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slpa_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [slpa_pkg::ADDR_W-1:0] mgmtBaseAddrStrap,
  input wire logic [slpa_pkg::MODE_W-1:0] deviceModeStrap,
  input wire logic broadcastAccessStrap,
  input wire logic lampStyleStrap,
  input wire logic [slpa_pkg::LAMP_N-1:0] lampPinIn,
  input wire logic [slpa_pkg::LAMP_N-1:0] lampActivity,
  input wire logic [slpa_pkg::ADDR_W-1:0] mgmtAddr,
  input wire logic mgmtAddrValid,
  output logic [slpa_pkg::LAMP_N-1:0] lampPinOut,
  output logic lampDriveEnN,
  output logic [slpa_pkg::LAMP_N-1:0] lampPolarityBit,
  output logic [slpa_pkg::LAMP_N-1:0] lampStyleIndividual,
  output logic [slpa_pkg::MODE_W-1:0] deviceMode,
  output logic broadcastEnable,
  output logic strapsLatched,
  output logic baseAddrOverLimit,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr0,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr1,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr2,
  output logic [slpa_pkg::ADDR_W-1:0] portAddr3,
  output logic [slpa_pkg::PORT_N-1:0] portHit
);
  import slpa_pkg::*;

  // ***********************************************************************
  // State
  // ***********************************************************************
  typedef struct packed {
    slpa_cap_t cap;
    logic [CNT_W-1:0] cnt;
    logic latched;
    logic [ADDR_W-1:0] base;
    logic [MODE_W-1:0] mode;
    logic bcastStrap;
    logic styleStrap;
    logic [LAMP_N-1:0] lampStrap;
    logic baseOver;
    logic [LAMP_N-1:0] pol;
    logic bcastEn;
    logic styleInd;
    logic [LAMP_N-1:0] styleVec;
    logic [LAMP_N-1:0] lampOut;
    logic lampEnN;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } slpa_main_st_t;

  slpa_main_st_t st;
  slpa_main_st_t next_st;
  logic [STRAP_W-1:0] strapRaw;
  logic [STRAP_W-1:0] strapSync;
  logic [ADDR_W-1:0] mapAddr0;
  logic [ADDR_W-1:0] mapAddr1;
  logic [ADDR_W-1:0] mapAddr2;
  logic [ADDR_W-1:0] mapAddr3;
  logic [PORT_N-1:0] mapHit;

  // ***********************************************************************
  // Pin synchroniser and port address map
  // ***********************************************************************
  // Lamp pins are sampled here at all times; the capture takes them only while they are released
  assign strapRaw = {lampPinIn, lampStyleStrap, broadcastAccessStrap,
                     deviceModeStrap, mgmtBaseAddrStrap};

  slpa_sync3 u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pinIn(strapRaw),
    .agreed(strapSync)
  );

  slpa_port_map u_map (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .latched(st.latched),
    .base(st.base),
    .bcastEn(st.bcastEn),
    .mgmtAddr(mgmtAddr),
    .mgmtAddrValid(mgmtAddrValid),
    .portAddr0(mapAddr0),
    .portAddr1(mapAddr1),
    .portAddr2(mapAddr2),
    .portAddr3(mapAddr3),
    .portHit(mapHit)
  );

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  // Capture, lamp drive and register access in one pass
  always_comb begin
    logic [31:0] rd;
    logic rdErr;
    rd = '0;
    rdErr = 1'b0;
    next_st = st;

    // Capture sequencer waits for the synchroniser to fill, then locks
    case (st.cap)
      CAP_SETTLE: begin
        if (st.cnt == SETTLE_LAST) begin
          next_st.cap = CAP_HELD;
          next_st.latched = 1'b1;
          next_st.base = strapSync[SB_BASE +: ADDR_W];
          next_st.mode = strapSync[SB_MODE +: MODE_W];
          next_st.bcastStrap = strapSync[SB_BCAST];
          next_st.styleStrap = strapSync[SB_STYLE];
          next_st.lampStrap = strapSync[SB_LAMP +: LAMP_N];
          // Low strap means a lamp to ground, so drive it high
          next_st.pol = ~strapSync[SB_LAMP +: LAMP_N];
          next_st.bcastEn = ~strapSync[SB_BCAST];
          next_st.styleInd = strapSync[SB_STYLE];
          // Flag a strap the board should never make; addresses wrap
          next_st.baseOver = strapSync[SB_BASE +: ADDR_W] > BASE_MAX;
        end else begin
          next_st.cnt = CNT_W'(st.cnt + 1'b1);
        end
      end
      CAP_HELD: begin
        // Nothing recaptures until the next reset
        next_st.cap = CAP_HELD;
      end
      default: begin
        next_st.cap = CAP_SETTLE;
      end
    endcase

    // Same style on every lamp output
    next_st.styleVec = {LAMP_N{st.styleInd}};

    // Lamp pins stay released until straps are safely caught
    if (st.latched) begin
      next_st.lampOut = lampActivity ~^ st.pol;
      next_st.lampEnN = 1'b0;
    end else begin
      next_st.lampOut = '0;
      next_st.lampEnN = 1'b1;
    end

    // Read mux for the register in the setup cycle
    if (paddr == REG_STRAPS) begin
      rd[RD_BASE +: ADDR_W] = st.base;
      rd[RD_MODE +: MODE_W] = st.mode;
      rd[RD_BCAST] = st.bcastStrap;
      rd[RD_STYLE] = st.styleStrap;
      rd[RD_LAMP +: LAMP_N] = st.lampStrap;
    end else if (paddr == REG_LAMP_POL) begin
      rd[LAMP_N-1:0] = st.pol;
    end else if (paddr == REG_CONFIG) begin
      rd[CFG_BCAST] = st.bcastEn;
      rd[CFG_STYLE] = st.styleInd;
    end else if (paddr == REG_PORT_ADDR) begin
      rd[0 * RD_PORT_STRIDE +: ADDR_W] = mapAddr0;
      rd[1 * RD_PORT_STRIDE +: ADDR_W] = mapAddr1;
      rd[2 * RD_PORT_STRIDE +: ADDR_W] = mapAddr2;
      rd[3 * RD_PORT_STRIDE +: ADDR_W] = mapAddr3;
    end else if (paddr == REG_STATUS) begin
      rd[STAT_LATCHED] = st.latched;
      rd[STAT_OVER] = st.baseOver;
    end else begin
      rdErr = 1'b1;
    end

    // Zero wait state slave: ready is raised for the access cycle only
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel && !penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = rdErr;
      next_st.prdata = (pwrite || rdErr) ? 32'h0000_0000 : rd;
    end

    // Writes land at the completing edge; after capture so software wins
    if (psel && penable && st.pready && pwrite && !st.pslverr && pstrb[0]) begin
      if (paddr == REG_LAMP_POL) begin
        next_st.pol = pwdata[LAMP_N-1:0];
      end else if (paddr == REG_CONFIG) begin
        next_st.bcastEn = pwdata[CFG_BCAST];
        next_st.styleInd = pwdata[CFG_STYLE];
      end
    end
  end

  // ***********************************************************************
  // Registers
  // ***********************************************************************
  // Clock enable low freezes everything
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
      st.cap <= CAP_SETTLE;
      st.lampEnN <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign lampPinOut = st.lampOut;
  assign lampDriveEnN = st.lampEnN;
  assign lampPolarityBit = st.pol;
  assign lampStyleIndividual = st.styleVec;
  assign deviceMode = st.mode;
  assign broadcastEnable = st.bcastEn;
  assign strapsLatched = st.latched;
  assign baseAddrOverLimit = st.baseOver;
  assign portAddr0 = mapAddr0;
  assign portAddr1 = mapAddr1;
  assign portAddr2 = mapAddr2;
  assign portAddr3 = mapAddr3;
  assign portHit = mapHit;

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence capEdge;
    $rose(st.latched);
  endsequence

  sequence apbSetup;
    ce && psel && !penable && !st.pready;
  endsequence

  sequence apbDone;
    ce && psel && penable && st.pready;
  endsequence

  // Caught address equals the agreed strap level
  chk_base_capture: assert property (capEdge |->
      st.base == $past(strapSync[SB_BASE +: ADDR_W]))
    else $error("base address not caught from straps");

  // Caught copy never moves while held
  chk_held_stable: assert property (st.latched && $past(st.latched) |->
      $stable(st.base) && $stable(st.mode) && $stable(st.lampStrap) && $stable(st.baseOver))
    else $error("caught strap changed while held");

  // Low strap gives polarity one
  chk_pol_low: assert property (capEdge |->
      (st.pol & ~$past(strapSync[SB_LAMP +: LAMP_N])) == ~$past(strapSync[SB_LAMP +: LAMP_N]))
    else $error("low lamp strap did not set polarity");

  // High strap gives polarity zero
  chk_pol_high: assert property (capEdge |->
      (st.pol & $past(strapSync[SB_LAMP +: LAMP_N])) == '0)
    else $error("high lamp strap did not clear polarity");

  // Lamp pin follows activity through the polarity
  chk_drive_level: assert property ($past(ce && resetn && st.latched) |->
      lampPinOut == $past(lampActivity ~^ st.pol) && !lampDriveEnN)
    else $error("lamp pin level wrong for polarity");

  // Mode caught once, one copy for all ports
  chk_mode_capture: assert property (capEdge |->
      deviceMode == $past(strapSync[SB_MODE +: MODE_W]))
    else $error("device mode not caught from straps");

  // Broadcast default is the inverse of its strap
  chk_bcast_default: assert property (capEdge |->
      broadcastEnable == ~$past(strapSync[SB_BCAST]))
    else $error("broadcast default wrong");

  // Style default follows its strap
  chk_style_default: assert property (capEdge |->
      st.styleInd == $past(strapSync[SB_STYLE]))
    else $error("lamp style default wrong");

  // Every lamp carries the same style
  chk_style_all: assert property ($past(ce && resetn) |->
      lampStyleIndividual == {LAMP_N{$past(st.styleInd)}})
    else $error("lamp style not uniform");

  // Top port sits at base plus three
  chk_port_addr: assert property ($past(ce && resetn && st.latched) |->
      portAddr3 == ADDR_W'(st.base + 3'd3) && portAddr0 == st.base)
    else $error("port address not base plus index");

  // Broadcast hit reaches all ports
  chk_bcast_hit: assert property ($past(ce && resetn && st.latched && st.bcastEn &&
      mgmtAddrValid && mgmtAddr == BCAST_ADDR) |-> portHit == {PORT_N{1'b1}})
    else $error("broadcast access missed a port");

  // Base over limit flag matches the caught value
  chk_over_flag: assert property (st.latched |-> st.baseOver == (st.base > BASE_MAX))
    else $error("base limit flag wrong");

  // Setup answered next cycle, ready drops after completion
  chk_apb_ready: assert property (apbSetup |=> st.pready and (apbDone |=> !st.pready))
    else $error("apb ready timing wrong");

endmodule

// ### slpa_strap_pulls.sv
// Board pull resistors on the strap pins, plus the shared lamp pins.
// Assumes the bench sets the resistor levels before reset is released.
`timescale 1ns/1ps
module slpa_strap_pulls
  import slpa_pkg::*;
(
  input wire logic [slpa_pkg::ADDR_W-1:0] baseRes,
  input wire logic [slpa_pkg::MODE_W-1:0] modeRes,
  input wire logic bcastRes,
  input wire logic styleRes,
  input wire logic [slpa_pkg::LAMP_N-1:0] lampRes,
  input wire logic overOk,
  input wire logic [slpa_pkg::LAMP_N-1:0] lampPinOut,
  input wire logic lampDriveEnN,
  output logic [slpa_pkg::ADDR_W-1:0] mgmtBaseAddrStrap,
  output logic [slpa_pkg::MODE_W-1:0] deviceModeStrap,
  output logic broadcastAccessStrap,
  output logic lampStyleStrap,
  output logic [slpa_pkg::LAMP_N-1:0] lampPinIn
);
  // ***********************************************************************
  // Resistor levels
  // ***********************************************************************
  // A sane board never straps a base above the limit; overOk breaks that
  assign mgmtBaseAddrStrap = (baseRes > BASE_MAX && !overOk) ? BASE_MAX : baseRes;
  assign deviceModeStrap = modeRes;
  assign broadcastAccessStrap = bcastRes;
  assign lampStyleStrap = styleRes;
  // Lamp pin shows the resistor until the device starts driving it
  assign lampPinIn = lampDriveEnN ? lampRes : lampPinOut;
endmodule

// ### slpa_strap_latch_test.sv
// Self-checking bench for the strap latch: straps, decode, lamps and APB.
// Assumes the pull model stands on the strap pins and one 200 MHz clock.
`timescale 1ns/1ps
module slpa_strap_latch_test;
  import slpa_pkg::*;
  logic clk, resetn, ce, psel, penable, pwrite, pready, pslverr, mgmtAddrValid;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [ADDR_W-1:0] baseStrap, baseRes, mgmtAddr, portAddr0, portAddr1, portAddr2, portAddr3;
  logic [MODE_W-1:0] modeStrap, modeRes, deviceMode;
  logic bcastStrap, bcastRes, styleStrap, styleRes, overOk;
  logic lampDriveEnN, broadcastEnable, strapsLatched, baseAddrOverLimit;
  logic [LAMP_N-1:0] lampRes, lampPinIn, lampPinOut, lampActivity;
  logic [LAMP_N-1:0] lampPolarityBit, lampStyleIndividual;
  logic [PORT_N-1:0] portHit;
  logic [ADDR_W-1:0] expBase;
  logic [MODE_W-1:0] expMode;
  logic expBcast, expStyle;
  logic [LAMP_N-1:0] expLamp;
  logic [31:0] rd, regExp[5];
  logic err;
  logic [PADDR_W-1:0] regAddr[5];
  int nErrors, cmpCount, cycles, n;

  slpa_strap_latch dut_u (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mgmtBaseAddrStrap(baseStrap),
    .deviceModeStrap(modeStrap), .broadcastAccessStrap(bcastStrap), .lampStyleStrap(styleStrap),
    .lampPinIn(lampPinIn), .lampActivity(lampActivity), .mgmtAddr(mgmtAddr),
    .mgmtAddrValid(mgmtAddrValid), .lampPinOut(lampPinOut), .lampDriveEnN(lampDriveEnN),
    .lampPolarityBit(lampPolarityBit), .lampStyleIndividual(lampStyleIndividual),
    .deviceMode(deviceMode), .broadcastEnable(broadcastEnable), .strapsLatched(strapsLatched),
    .baseAddrOverLimit(baseAddrOverLimit), .portAddr0(portAddr0), .portAddr1(portAddr1),
    .portAddr2(portAddr2), .portAddr3(portAddr3), .portHit(portHit));

  slpa_strap_pulls pulls_u (.baseRes(baseRes), .modeRes(modeRes), .bcastRes(bcastRes),
    .styleRes(styleRes), .lampRes(lampRes), .overOk(overOk), .lampPinOut(lampPinOut),
    .lampDriveEnN(lampDriveEnN), .mgmtBaseAddrStrap(baseStrap), .deviceModeStrap(modeStrap),
    .broadcastAccessStrap(bcastStrap), .lampStyleStrap(styleStrap), .lampPinIn(lampPinIn));

  // ***********************************************************************
  // Clock, timeout and reporting
  // ***********************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run needs about three hundred and twenty cycles; five thousand means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nErrors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ***********************************************************************
  // Access tasks
  // ***********************************************************************
  // Request held until pready is seen high at an edge, then released
  task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // Nothing but the bench timeout bounds this wait
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Slave answers in the first access cycle
    check(k, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Decode result is registered, so it is looked at one edge later
  task automatic probe(input logic [ADDR_W-1:0] a, input logic v);
    logic [PORT_N-1:0] e;
    e = '0;
    for (int i = 0; i < PORT_N; i++) begin
      e[i] = v && (a == 5'(expBase + 5'(i)) || (!expBcast && a == BCAST_ADDR));
    end
    @(posedge clk);
    mgmtAddr <= a;
    mgmtAddrValid <= v;
    @(posedge clk);
    @(posedge clk);
    check({28'h0, portHit}, {28'h0, e});
  endtask

  task automatic check_latched();
    logic [ADDR_W-1:0] pa[4];
    pa = '{portAddr0, portAddr1, portAddr2, portAddr3};
    for (int i = 0; i < PORT_N; i++) begin
      check({27'h0, pa[i]}, {27'h0, 5'(expBase + 5'(i))});
    end
    check({27'h0, deviceMode}, {27'h0, expMode});
    check({31'h0, broadcastEnable}, {31'h0, !expBcast});
    check({24'h0, lampStyleIndividual}, {24'h0, {LAMP_N{expStyle}}});
    check({24'h0, lampPolarityBit}, {24'h0, ~expLamp});
    check({31'h0, baseAddrOverLimit}, {31'h0, expBase > BASE_MAX});
    check({31'h0, strapsLatched}, 32'h1);
  endtask

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    {resetn, ce, psel, penable, pwrite, mgmtAddrValid, overOk} = 7'b0100000;
    {paddr, pwdata, pstrb, mgmtAddr, lampActivity, cycles, nErrors, cmpCount} = '0;
    pstrb = 4'h1;
    {baseRes, modeRes, bcastRes, styleRes, lampRes} = '0;
    regAddr = '{REG_STRAPS, REG_LAMP_POL, REG_CONFIG, REG_PORT_ADDR, REG_STATUS};
    for (int s = 0; s < 3; s++) begin
      // Top legal base, zero base, and a board that breaks the limit
      expBase = (s == 0) ? 5'h1c : (s == 1) ? 5'h00 : 5'h1f;
      expMode = (s == 0) ? 5'h19 : (s == 1) ? 5'h0a : 5'h10;
      expBcast = (s == 1);
      expStyle = (s != 1);
      expLamp = (s == 0) ? 8'ha5 : (s == 1) ? 8'h3c : 8'h0f;
      @(posedge clk);
      {baseRes, modeRes, bcastRes, styleRes, lampRes} <=
        {expBase, expMode, expBcast, expStyle, expLamp};
      overOk <= (s == 2);
      resetn <= 1'b0;
      repeat (12) @(posedge clk);
      check({31'h0, lampDriveEnN}, 32'h1);
      resetn <= 1'b1;
      n = 0;
      while (strapsLatched !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      // Port addresses and lamp style trail the capture by one edge
      @(posedge clk);
      check_latched();
      regExp[0] = {expLamp, 6'h0, expStyle, expBcast, 3'h0, expMode, 3'h0, expBase};
      regExp[1] = {24'h0, ~expLamp};
      regExp[2] = {30'h0, expStyle, !expBcast};
      regExp[3] = '0;
      for (int i = 0; i < PORT_N; i++) begin
        regExp[3][RD_PORT_STRIDE*i +: ADDR_W] = 5'(expBase + 5'(i));
      end
      regExp[4] = {30'h0, expBase > BASE_MAX, 1'b1};
      for (int r = 0; r < 5; r++) begin
        apb(1'b0, regAddr[r], 32'h0);
        check(rd, regExp[r]);
      end
      for (int i = 0; i < PORT_N; i++) begin
        probe(5'(expBase + 5'(i)), 1'b1);
      end
      probe(BCAST_ADDR, 1'b1);
      probe(5'(expBase + 5'h04), 1'b1);
      probe(expBase, 1'b0);
      @(posedge clk);
      lampActivity <= 8'h96;
      @(posedge clk);
      @(posedge clk);
      check({24'h0, lampPinOut}, {24'h0, ~(8'h96 ^ ~expLamp)});
      check({31'h0, lampDriveEnN}, 32'h0);
      // Clock enable low must freeze the lamp drive
      ce <= 1'b0;
      lampActivity <= 8'h69;
      repeat (3) @(posedge clk);
      check({24'h0, lampPinOut}, {24'h0, ~(8'h96 ^ ~expLamp)});
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      check({24'h0, lampPinOut}, {24'h0, ~(8'h69 ^ ~expLamp)});
      // Move every resistor; the caught copy must not follow
      @(posedge clk);
      {baseRes, modeRes, bcastRes, styleRes, lampRes} <=
        ~{expBase, expMode, expBcast, expStyle, expLamp};
      repeat (10) @(posedge clk);
      check_latched();
      apb(1'b1, REG_STRAPS, 32'hffffffff);
      apb(1'b0, REG_STRAPS, 32'h0);
      check(rd, regExp[0]);
      apb(1'b1, REG_LAMP_POL, 32'h0000005a);
      @(posedge clk);
      check({24'h0, lampPolarityBit}, 32'h0000005a);
      // A write with its low byte strobe off must be ignored
      pstrb <= 4'h0;
      apb(1'b1, REG_LAMP_POL, 32'h000000ff);
      pstrb <= 4'h1;
      apb(1'b0, REG_LAMP_POL, 32'h0);
      check(rd, 32'h0000005a);
      apb(1'b0, 12'h100, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b0, 12'h002, 32'h0);
      check({31'h0, err}, 32'h1);
      // Software overrides both defaults; the next reset restores them
      apb(1'b1, REG_CONFIG, {30'h0, !expStyle, expBcast});
      apb(1'b0, REG_CONFIG, 32'h0);
      check(rd, {30'h0, !expStyle, expBcast});
      check({31'h0, broadcastEnable}, {31'h0, expBcast});
      check({24'h0, lampStyleIndividual}, {24'h0, {LAMP_N{!expStyle}}});
      expBcast = !expBcast;
      probe(BCAST_ADDR, 1'b1);
      $display("strap set %0d finished", s);
    end
    end_of_test();
  end
endmodule
